// ==== rfd_pkg.sv ====
// Package with register map, field positions and symbol codes of the receive frame decoder.
package rfd_pkg;
  localparam logic [7:0] ADDR_BIT_FRAMING = 8'h58;
  localparam logic [7:0] ADDR_EOF_PATTERN = 8'h59;
  localparam logic [7:0] ADDR_SOF_HIGH = 8'h5a;
  localparam logic [7:0] ADDR_SOF_LOW = 8'h5b;
  localparam logic [7:0] ADDR_SOF_MODE = 8'h5c;
  localparam logic [7:0] ADDR_STATUS = 8'h5d;
  localparam int BIT_STOP_INV_PAR = 5;
  localparam int BIT_STOP_LENGTH = 4;
  localparam int BIT_MSB_FIRST = 3;
  localparam int BIT_STOP_BIT_EN = 2;
  localparam int BIT_ODD_PARITY = 1;
  localparam logic [7:0] FRAMING_WRITE_MASK = 8'h3e;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [1:0] EOF_NONE = 2'h0;
  localparam logic [1:0] EOF_ZERO = 2'h1;
  localparam logic [1:0] EOF_ONE = 2'h2;
  localparam logic [1:0] EOF_COLL = 2'h3;
  localparam logic [1:0] SOF_BURST = 2'h0;
  localparam logic [1:0] SOF_NIBBLE = 2'h1;
  localparam logic [1:0] SOF_START_BIT = 2'h2;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SOF = 3'b001,
    ST_DATA = 3'b010,
    ST_PARITY = 3'b011,
    ST_STOP = 3'b100,
    ST_DONE = 3'b101
  } rfd_state_t;
endpackage

// ==== rfd_decoder.sv ====
// Receive frame decoder: start-of-frame match, byte assembly, parity, stop bit and end symbol.
//
// Overview of operation
// - With stop_on_inverse_parity set, a parity bit of wrong value ends reception.
// - With stop_at_frame_length set, reception ends when byte count reaches frame length.
// - The frame length is the value of the first received data byte.
// - msb_first_order 1 puts first bit at MSB; 0 puts it at LSB.
// - With stop bits enabled, a stop bit follows each byte, checked and removed.
// - Each detected stop bit emits a resync pulse to the demodulator.
// - A wrong stop bit sets the frame error flag and aborts reception.
// - A stop bit is correct only when it is logic 1.
// - odd_parity_select 0 gives even parity, 1 gives odd parity.
// - The end pattern register holds up to four symbol bits, two bits each.
// - A 00 field closes the end symbol, allowing shorter symbols.
// - Fields fill from bits 1:0; the leftmost active field is expected first.
// - A zero lowest field disables end symbol detection.
// - Field codes: 0 none, 1 zero bit, 2 one bit, 3 collision.
// - The upper start pattern byte comes from the high-byte register.
// - The lower start pattern byte comes from the low-byte register.
// - sof_valid_bit_count gives how many pattern bits are matched; 0 means type B.
// - sof_interpretation_type selects burst, nibble-with-collision or start-bit sync.
`timescale 1ns/1ps
`default_nettype none
module rfd_decoder (
  // Clock and reset.
  input wire logic mclk,
  input wire logic nrst,
  // Register port.
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Demodulated bit stream, one bit per valid strobe.
  input wire logic rx_start,
  input wire logic bit_valid,
  input wire logic bit_value,
  input wire logic bit_coll,
  // Decoded byte stream.
  output logic byte_valid,
  output logic [7:0] byte_data,
  output logic parity_error,
  output logic frame_error,
  output logic frame_done,
  output logic rx_active,
  output logic demod_resync
);
  // Configuration registers.
  logic [7:0] framing;
  logic [7:0] eof_symbol_pattern;
  logic [7:0] sof_pattern_high_byte;
  logic [7:0] sof_pattern_low_byte;
  logic [7:0] sof_mode;
  rfd_pkg::rfd_state_t state;
  logic [15:0] sof_shift;
  logic [4:0] sof_cnt;
  logic [7:0] shreg;
  logic [2:0] bit_idx;
  logic [7:0] byte_cnt;
  logic [7:0] frame_len;
  logic par_acc;
  logic [7:0] cur_byte;
  logic [3:0] eof_hist;
  logic [3:0] eof_coll;
  logic [2:0] eof_seen;

  // Field decode of the control registers.
  wire stop_on_inverse_parity = framing[rfd_pkg::BIT_STOP_INV_PAR];
  wire stop_at_frame_length = framing[rfd_pkg::BIT_STOP_LENGTH];
  wire msb_first_order = framing[rfd_pkg::BIT_MSB_FIRST];
  wire stop_bit_check_enable = framing[rfd_pkg::BIT_STOP_BIT_EN];
  wire odd_parity_select = framing[rfd_pkg::BIT_ODD_PARITY];
  wire [3:0] sof_valid_bit_count = sof_mode[7:4];
  wire [1:0] sof_interpretation_type = sof_mode[1:0];
  wire [15:0] sof_pattern = {sof_pattern_high_byte, sof_pattern_low_byte};

  // End symbol length: count of active fields up to the first 00 field.
  wire [1:0] f0 = eof_symbol_pattern[1:0];
  wire [1:0] f1 = eof_symbol_pattern[3:2];
  wire [1:0] f2 = eof_symbol_pattern[5:4];
  wire [1:0] f3 = eof_symbol_pattern[7:6];
  wire [2:0] eof_len = (f0 == rfd_pkg::EOF_NONE) ? 3'h0 :
                       (f1 == rfd_pkg::EOF_NONE) ? 3'h1 :
                       (f2 == rfd_pkg::EOF_NONE) ? 3'h2 :
                       (f3 == rfd_pkg::EOF_NONE) ? 3'h3 : 3'h4;
  wire eof_enabled = (eof_len != 3'h0);

  // Each field compares against one received bit; the highest active field is sent first.
  function automatic logic field_match(input logic [1:0] f, input logic v, input logic c);
    logic m;
    m = 1'b0;
    case (f)
      rfd_pkg::EOF_ZERO: m = !c && !v;
      rfd_pkg::EOF_ONE: m = !c && v;
      rfd_pkg::EOF_COLL: m = c;
      default: m = 1'b0;
    endcase
    return m;
  endfunction

  // The newest bit is history bit 0 (incoming), so field k pairs with the bit k steps back.
  wire [3:0] hv = {eof_hist[2:0], bit_value};
  wire [3:0] hc = {eof_coll[2:0], bit_coll};
  wire [2:0] next_seen = (eof_seen == 3'h4) ? 3'h4 : eof_seen + 3'h1;
  wire m0 = field_match(f0, hv[0], hc[0]);
  wire m1 = (eof_len < 3'h2) || field_match(f1, hv[1], hc[1]);
  wire m2 = (eof_len < 3'h3) || field_match(f2, hv[2], hc[2]);
  wire m3 = (eof_len < 3'h4) || field_match(f3, hv[3], hc[3]);
  wire eof_hit = eof_enabled && bit_valid && (next_seen >= eof_len) && m0 && m1 && m2 && m3;

  // Start pattern match: compare the valid low bits of the shift history.
  wire [15:0] next_sof_shift = {sof_shift[14:0], bit_value};
  wire [15:0] sof_mask = (16'h0001 << sof_valid_bit_count) - 16'h0001;
  wire sof_burst_hit = ((next_sof_shift ^ sof_pattern) & sof_mask) == 16'h0000;
  // In nibble mode each nibble is {data, coll}; a collision nibble matches a collided bit.
  wire [3:0] sof_nib = sof_pattern[{sof_cnt[1:0], 2'b00} +: 4];
  wire sof_nib_ok = sof_nib[0] ? bit_coll : (bit_value == sof_nib[1]);
  wire sof_type_b = (sof_valid_bit_count == 4'h0) || (sof_interpretation_type == rfd_pkg::SOF_START_BIT);

  // Byte assembly and parity.
  wire [7:0] next_shreg = msb_first_order ? {shreg[6:0], bit_value} :
                                            {bit_value, shreg[7:1]};
  wire expected_parity = par_acc ^ odd_parity_select;
  wire parity_bad = bit_valid && (bit_value != expected_parity);
  wire stop_ok = bit_value;
  wire [7:0] next_byte_cnt = byte_cnt + 8'h01;
  wire len_reached = stop_at_frame_length && (byte_cnt != 8'h00) &&
                     (next_byte_cnt == frame_len);
  wire [7:0] rd_mux = (reg_addr == rfd_pkg::ADDR_BIT_FRAMING) ? framing :
                      (reg_addr == rfd_pkg::ADDR_EOF_PATTERN) ? eof_symbol_pattern :
                      (reg_addr == rfd_pkg::ADDR_SOF_HIGH) ? sof_pattern_high_byte :
                      (reg_addr == rfd_pkg::ADDR_SOF_LOW) ? sof_pattern_low_byte :
                      (reg_addr == rfd_pkg::ADDR_SOF_MODE) ? sof_mode :
                      (reg_addr == rfd_pkg::ADDR_STATUS) ?
                        {4'h0, rx_active, frame_done, frame_error, parity_error} :
                      rfd_pkg::RESET_BYTE;

  // Register writes; reserved framing bits never store.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      framing <= rfd_pkg::RESET_BYTE;
      eof_symbol_pattern <= rfd_pkg::RESET_BYTE;
      sof_pattern_high_byte <= rfd_pkg::RESET_BYTE;
      sof_pattern_low_byte <= rfd_pkg::RESET_BYTE;
      sof_mode <= rfd_pkg::RESET_BYTE;
    end else if (reg_wr) begin
      if (reg_addr == rfd_pkg::ADDR_BIT_FRAMING) begin
        framing <= reg_wdata & rfd_pkg::FRAMING_WRITE_MASK;
      end
      if (reg_addr == rfd_pkg::ADDR_EOF_PATTERN) begin
        eof_symbol_pattern <= reg_wdata;
      end
      if (reg_addr == rfd_pkg::ADDR_SOF_HIGH) begin
        sof_pattern_high_byte <= reg_wdata;
      end
      if (reg_addr == rfd_pkg::ADDR_SOF_LOW) begin
        sof_pattern_low_byte <= reg_wdata;
      end
      if (reg_addr == rfd_pkg::ADDR_SOF_MODE) begin
        sof_mode <= reg_wdata;
      end
    end
  end

  // Read data stand for exactly the cycle after the strobe.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= rfd_pkg::RESET_BYTE;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : rfd_pkg::RESET_BYTE;
    end
  end

  // Frame sequencer. Pulses default low each cycle; sticky flags clear on a new frame.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state <= rfd_pkg::ST_IDLE;
      sof_shift <= 16'h0000;
      sof_cnt <= 5'h00;
      shreg <= 8'h00;
      bit_idx <= 3'h0;
      byte_cnt <= 8'h00;
      frame_len <= 8'h00;
      par_acc <= 1'b0;
      cur_byte <= 8'h00;
      eof_hist <= 4'h0;
      eof_coll <= 4'h0;
      eof_seen <= 3'h0;
      byte_valid <= 1'b0;
      byte_data <= 8'h00;
      parity_error <= 1'b0;
      frame_error <= 1'b0;
      frame_done <= 1'b0;
      rx_active <= 1'b0;
      demod_resync <= 1'b0;
    end else begin
      byte_valid <= 1'b0;
      demod_resync <= 1'b0;
      if (bit_valid && state != rfd_pkg::ST_IDLE && state != rfd_pkg::ST_SOF) begin
        eof_hist <= hv;
        eof_coll <= hc;
        eof_seen <= next_seen;
      end
      if (rx_start) begin
        state <= rfd_pkg::ST_SOF;
        sof_shift <= 16'h0000;
        sof_cnt <= 5'h00;
        byte_cnt <= 8'h00;
        frame_len <= 8'h00;
        eof_seen <= 3'h0;
        parity_error <= 1'b0;
        frame_error <= 1'b0;
        frame_done <= 1'b0;
        rx_active <= 1'b1;
      end else begin
        unique case (state)
          rfd_pkg::ST_IDLE: begin
          end
          rfd_pkg::ST_SOF: begin
            // Data are only taken once the start pattern has completed.
            if (sof_type_b) begin
              state <= rfd_pkg::ST_DATA;
            end else if (bit_valid) begin
              sof_shift <= next_sof_shift;
              sof_cnt <= sof_cnt + 5'h01;
              if (sof_interpretation_type == rfd_pkg::SOF_NIBBLE) begin
                if (!sof_nib_ok) begin
                  sof_cnt <= 5'h00;
                end else if (sof_cnt[1:0] == sof_valid_bit_count[1:0] - 2'h1) begin
                  state <= rfd_pkg::ST_DATA;
                end
              end else if ((sof_cnt + 5'h01 >= {1'b0, sof_valid_bit_count}) && sof_burst_hit) begin
                state <= rfd_pkg::ST_DATA;
              end
            end
            bit_idx <= 3'h0;
            par_acc <= 1'b0;
          end
          rfd_pkg::ST_DATA: begin
            if (eof_hit) begin
              state <= rfd_pkg::ST_DONE;
              frame_done <= 1'b1;
            end else if (bit_valid) begin
              shreg <= next_shreg;
              par_acc <= par_acc ^ bit_value;
              bit_idx <= bit_idx + 3'h1;
              if (bit_idx == 3'h7) begin
                state <= rfd_pkg::ST_PARITY;
                cur_byte <= next_shreg;
              end
            end
          end
          rfd_pkg::ST_PARITY: begin
            if (bit_valid) begin
              parity_error <= parity_error | parity_bad;
              byte_valid <= 1'b1;
              byte_data <= cur_byte;
              byte_cnt <= next_byte_cnt;
              bit_idx <= 3'h0;
              par_acc <= 1'b0;
              if (byte_cnt == 8'h00) begin
                frame_len <= cur_byte;
              end
              if (stop_on_inverse_parity && parity_bad) begin
                state <= rfd_pkg::ST_DONE;
                frame_done <= 1'b1;
              end else if (len_reached) begin
                state <= rfd_pkg::ST_DONE;
                frame_done <= 1'b1;
              end else if (stop_bit_check_enable) begin
                state <= rfd_pkg::ST_STOP;
              end else begin
                state <= rfd_pkg::ST_DATA;
              end
            end
          end
          rfd_pkg::ST_STOP: begin
            // The stop bit is consumed here and never reaches the byte stream.
            if (bit_valid) begin
              demod_resync <= 1'b1;
              if (stop_ok) begin
                state <= rfd_pkg::ST_DATA;
              end else begin
                frame_error <= 1'b1;
                state <= rfd_pkg::ST_DONE;
              end
            end
          end
          rfd_pkg::ST_DONE: begin
            rx_active <= 1'b0;
            state <= rfd_pkg::ST_IDLE;
          end
          default: begin
            state <= rfd_pkg::ST_IDLE;
          end
        endcase
      end
    end
  end

  // A bad stop bit raises the frame error at the next edge.
  a_stop_bit_error: assert property (@(posedge mclk) disable iff (!nrst)
    (state == rfd_pkg::ST_STOP && bit_valid && !bit_value && !rx_start) |=> frame_error)
    else $error("bad stop bit did not flag a frame error");

  // A good stop bit returns to data without error.
  a_stop_bit_good: assert property (@(posedge mclk) disable iff (!nrst)
    (state == rfd_pkg::ST_STOP && bit_valid && bit_value && !rx_start && !frame_error)
      |=> (state == rfd_pkg::ST_DATA && !frame_error))
    else $error("good stop bit handled wrongly");

  // Every stop bit pulses the resync line for one cycle.
  a_resync_pulse: assert property (@(posedge mclk) disable iff (!nrst)
    (state == rfd_pkg::ST_STOP && bit_valid && !rx_start) |=> demod_resync ##1 !demod_resync)
    else $error("resync pulse missing or too long");

  // Inverse parity with stop enabled ends the frame.
  a_inv_parity_stop: assert property (@(posedge mclk) disable iff (!nrst)
    (state == rfd_pkg::ST_PARITY && stop_on_inverse_parity && parity_bad && !rx_start)
      |=> (frame_done && state == rfd_pkg::ST_DONE))
    else $error("inverse parity did not end reception");

  // Parity flag follows the selected parity type.
  a_parity_type: assert property (@(posedge mclk) disable iff (!nrst)
    (state == rfd_pkg::ST_PARITY && bit_valid && !rx_start &&
     (bit_value != (^cur_byte ^ odd_parity_select))) |=> parity_error)
    else $error("parity type not honoured");

  // The first data bit enters the shift register at the end set by the bit order.
  a_byte_order: assert property (@(posedge mclk) disable iff (!nrst)
    (state == rfd_pkg::ST_DATA && bit_valid && bit_idx == 3'h0 && !eof_hit && !rx_start)
      |=> (msb_first_order ? shreg[0] : shreg[7]) == $past(bit_value))
    else $error("first bit landed at the wrong end");

  // The first byte becomes the frame length.
  a_length_capture: assert property (@(posedge mclk) disable iff (!nrst)
    (state == rfd_pkg::ST_PARITY && bit_valid && byte_cnt == 8'h00 && !rx_start)
      |=> frame_len == $past(cur_byte))
    else $error("frame length not taken from the first byte");

  // Length reached ends reception.
  a_length_stop: assert property (@(posedge mclk) disable iff (!nrst)
    (state == rfd_pkg::ST_PARITY && bit_valid && len_reached && !rx_start &&
     !(stop_on_inverse_parity && parity_bad)) |=> state == rfd_pkg::ST_DONE)
    else $error("reception ran past frame length");

  // Disabled end symbol never ends a frame from the data state.
  a_eof_disabled: assert property (@(posedge mclk) disable iff (!nrst)
    (state == rfd_pkg::ST_DATA && eof_symbol_pattern[1:0] == rfd_pkg::EOF_NONE && !rx_start)
      |=> state != rfd_pkg::ST_DONE)
    else $error("end symbol detected while disabled");

  // Reserved framing bits read zero.
  a_reserved_zero: assert property (@(posedge mclk) disable iff (!nrst)
    (framing & ~rfd_pkg::FRAMING_WRITE_MASK) == 8'h00)
    else $error("reserved framing bits not zero");

  // Reading the framing register never shows a reserved bit set.
  a_reserved_read: assert property (@(posedge mclk) disable iff (!nrst)
    (reg_rd && reg_addr == rfd_pkg::ADDR_BIT_FRAMING) |=> (reg_rdata & 8'hc1) == 8'h00)
    else $error("reserved framing bits read back set");

  // A complete end symbol in the data state closes the frame.
  a_eof_close: assert property (@(posedge mclk) disable iff (!nrst)
    (state == rfd_pkg::ST_DATA && eof_hit && !rx_start)
      |=> (frame_done && state == rfd_pkg::ST_DONE))
    else $error("end symbol did not close the frame");

  // The stop bit is consumed and never produces a byte.
  a_stop_removed: assert property (@(posedge mclk) disable iff (!nrst)
    (state == rfd_pkg::ST_STOP && bit_valid && !rx_start) |=> !byte_valid)
    else $error("stop bit passed on as data");

  // A bad stop bit aborts the reception at once.
  a_stop_abort: assert property (@(posedge mclk) disable iff (!nrst)
    (state == rfd_pkg::ST_STOP && bit_valid && !bit_value && !rx_start) |=> state == rfd_pkg::ST_DONE)
    else $error("bad stop bit did not abort reception");
endmodule
`default_nettype wire

// ==== rfd_card.sv ====
// Behavioural card model that plays queued bits onto the demodulated bit stream.
`timescale 1ns/1ps
`default_nettype none
module rfd_card (
  // Clock and reset.
  input wire logic mclk,
  input wire logic nrst,
  // Idle cycles between two bits (one at least, also for 0), so the card can be prompt or slow.
  input wire logic [1:0] gap,
  // Bit stream towards the decoder.
  output logic bit_valid,
  output logic bit_value,
  output logic bit_coll
);
  logic [1:0] bitq[$];
  logic [1:0] wait_cnt;

  // The bench files each bit as {collision, value}; the card sends them in order.
  task automatic push(input logic v, input logic c);
    bitq.push_back({c, v});
  endtask

  // Between bits the lines toggle, so a stale value never passes for data.
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      bit_valid <= 1'b0;
      bit_value <= 1'b0;
      bit_coll <= 1'b0;
      wait_cnt <= 2'h0;
    end else if (!bit_valid && wait_cnt == 2'h0 && bitq.size() != 0) begin
      {bit_coll, bit_value} <= bitq.pop_front();
      bit_valid <= 1'b1;
      wait_cnt <= gap;
    end else begin
      bit_valid <= 1'b0;
      bit_value <= ~bit_value;
      bit_coll <= ~bit_coll;
      if (wait_cnt != 2'h0) wait_cnt <= wait_cnt - 2'h1;
    end
  end
endmodule
`default_nettype wire

// ==== rx_frame_bit_decoder_tb.sv ====
// Self-checking testbench of the receive frame decoder with a card model.
`timescale 1ns/1ps
`default_nettype none
module rx_frame_bit_decoder_tb;
  logic mclk = 1'b0;
  logic nrst, reg_wr, reg_rd, rx_start, bit_valid, bit_value, bit_coll;
  logic rd_d = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, byte_data;
  logic byte_valid, parity_error, frame_error, frame_done, rx_active, demod_resync;
  logic [1:0] gap;
  logic [7:0] reg_q[$];
  logic [7:0] byte_q[$];
  int fails = 0;
  int cmp_count = 0;
  int nbytes = 0;
  int nsync = 0;

  // The clock runs at 200 MHz.
  always #2.5 mclk = ~mclk;

  rfd_decoder i_rfd_decoder (.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rx_start(rx_start), .bit_valid(bit_valid), .bit_value(bit_value), .bit_coll(bit_coll),
    .byte_valid(byte_valid), .byte_data(byte_data), .parity_error(parity_error),
    .frame_error(frame_error), .frame_done(frame_done), .rx_active(rx_active),
    .demod_resync(demod_resync));
  rfd_card i_rfd_card (.mclk(mclk), .nrst(nrst), .gap(gap), .bit_valid(bit_valid),
    .bit_value(bit_value), .bit_coll(bit_coll));

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic summarize();
    if (fails == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Strobes stay up across back-to-back accesses; quiet lowers them once.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    reg_q.push_back(exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    reg_wr <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic quiet();
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    @(posedge mclk);
  endtask

  // Configures framing, picks a pace for the card and opens a new frame.
  task automatic frame(input logic [7:0] cfg);
    wr(rfd_pkg::ADDR_BIT_FRAMING, cfg);
    quiet();
    gap <= 2'($urandom);
    rx_start <= 1'b1;
    nbytes = 0;
    nsync = 0;
    @(posedge mclk);
    rx_start <= 1'b0;
    // A type B frame spends one cycle entering data; no bit may arrive in it.
    @(posedge mclk);
  endtask

  // Eight data bits in the chosen order, the parity bit, then the optional stop bit.
  task automatic send_byte(input logic [7:0] b, input logic bad_par, input logic stop,
      input logic [7:0] cfg);
    for (int i = 0; i < 8; i++) begin
      i_rfd_card.push(cfg[rfd_pkg::BIT_MSB_FIRST] ? b[7 - i] : b[i], 1'b0);
    end
    i_rfd_card.push(^b ^ cfg[rfd_pkg::BIT_ODD_PARITY] ^ bad_par, 1'b0);
    if (cfg[rfd_pkg::BIT_STOP_BIT_EN]) i_rfd_card.push(stop, 1'b0);
  endtask

  // Waits, bounded, until the card has sent everything, then lets the outputs settle.
  task automatic drain();
    int n;
    n = 0;
    while ((i_rfd_card.bitq.size() != 0 || bit_valid) && n < 500) begin
      @(posedge mclk);
      n++;
    end
    if (n == 500) fails++;
    repeat (4) @(posedge mclk);
  endtask

  // Results are matched against the oldest note filed by the driver.
  always @(posedge mclk) begin
    if (rd_d && reg_q.size() != 0) check("reg_rdata", reg_q.pop_front(), reg_rdata);
    rd_d = reg_rd;
    if (byte_valid === 1'b1) begin
      nbytes++;
      if (byte_q.size() != 0) check("byte_data", byte_q.pop_front(), byte_data);
      else begin
        fails++;
        $display("BAD byte_data expected none seen %h", byte_data);
      end
    end
    if (demod_resync === 1'b1) nsync++;
  end

  initial begin
    logic [7:0] cfg, b;
    logic [11:0] pat;
    nrst = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    rx_start = 1'b0;
    gap = 2'h0;
    void'($urandom(32'h139c26a4));
    repeat (3) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    // Reset values, reserved framing bits, read-only status and unmapped space.
    for (int a = 8'h58; a <= 8'h5d; a++) rd(a[7:0], rfd_pkg::RESET_BYTE);
    wr(rfd_pkg::ADDR_BIT_FRAMING, 8'hff);
    rd(rfd_pkg::ADDR_BIT_FRAMING, rfd_pkg::FRAMING_WRITE_MASK);
    for (int a = 8'h59; a <= 8'h5b; a++) begin
      b = 8'($urandom);
      wr(a[7:0], b);
      rd(a[7:0], b);
    end
    wr(rfd_pkg::ADDR_STATUS, 8'hff);
    rd(rfd_pkg::ADDR_STATUS, 8'h00);
    rd(8'h60, 8'h00);
    wr(rfd_pkg::ADDR_EOF_PATTERN, 8'h00);
    quiet();
    // Every order, parity type and stop-bit setting over plain three-byte frames.
    for (int m = 0; m < 16; m++) begin
      cfg = {2'b00, m[3], 1'b0, m[2:0], 1'b0};
      frame(cfg);
      for (int k = 0; k < 3; k++) begin
        b = 8'($urandom);
        byte_q.push_back(b);
        send_byte(b, 1'b0, 1'b1, cfg);
      end
      drain();
      check("byte count", 8'd3, nbytes[7:0]);
      check("resync count", cfg[2] ? 8'd3 : 8'd0, nsync[7:0]);
      check("error flags", 8'h00, {6'h0, frame_error, parity_error});
      check("rx_active", 8'h01, {7'h0, rx_active});
    end
    // Inverse parity: only flagged, or a stop condition when enabled.
    for (int s = 0; s < 2; s++) begin
      cfg = s ? 8'h20 : 8'h00;
      frame(cfg);
      b = 8'($urandom);
      byte_q.push_back(b);
      byte_q.push_back(~b);
      if (s == 0) byte_q.push_back(b);
      send_byte(b, 1'b0, 1'b1, cfg);
      send_byte(~b, 1'b1, 1'b1, cfg);
      send_byte(b, 1'b0, 1'b1, cfg);
      drain();
      check("parity_error", 8'h01, {7'h0, parity_error});
      check("frame_done", 8'(s), {7'h0, frame_done});
      check("rx_active", 8'(1 - s), {7'h0, rx_active});
    end
    // Length taken from the first byte; bytes past that length are dropped.
    cfg = 8'h1c;
    frame(cfg);
    for (int k = 0; k < 4; k++) begin
      b = (k == 0) ? 8'h03 : 8'($urandom);
      if (k < 3) byte_q.push_back(b);
      send_byte(b, 1'b0, 1'b1, cfg);
    end
    drain();
    check("length bytes", 8'd3, nbytes[7:0]);
    check("length done", 8'h02, {6'h0, frame_done, rx_active});
    // A stop bit of value zero aborts the frame with a frame error.
    cfg = 8'h04;
    frame(cfg);
    b = 8'($urandom);
    byte_q.push_back(b);
    send_byte(b, 1'b0, 1'b0, cfg);
    send_byte(b, 1'b0, 1'b1, cfg);
    drain();
    check("stop abort", 8'h02, {6'h0, frame_error, rx_active});
    check("abort bytes", 8'd1, nbytes[7:0]);
    // Burst start pattern over twelve bits: a wrong pattern is refused, the right one opens data.
    wr(rfd_pkg::ADDR_SOF_HIGH, 8'h0c);
    wr(rfd_pkg::ADDR_SOF_LOW, 8'ha7);
    wr(rfd_pkg::ADDR_SOF_MODE, 8'hc0);
    pat = 12'hca7;
    for (int k = 0; k < 2; k++) begin
      frame(8'h00);
      for (int i = 11; i >= 0; i--) i_rfd_card.push(pat[i] ^ (i == 0 && k == 0), 1'b0);
      b = 8'($urandom);
      if (k == 1) byte_q.push_back(b);
      send_byte(b, 1'b0, 1'b1, 8'h00);
      drain();
      check("sof bytes", 8'(k), nbytes[7:0]);
    end
    // Nibble start pattern: a collided bit, then a one bit, opens data.
    wr(rfd_pkg::ADDR_SOF_LOW, 8'h21);
    wr(rfd_pkg::ADDR_SOF_MODE, 8'h21);
    frame(8'h00);
    i_rfd_card.push(1'b0, 1'b1);
    i_rfd_card.push(1'b1, 1'b0);
    b = 8'($urandom);
    byte_q.push_back(b);
    send_byte(b, 1'b0, 1'b1, 8'h00);
    drain();
    check("nibble bytes", 8'd1, nbytes[7:0]);
    // A zero lowest end-pattern field disables end-symbol detection.
    wr(rfd_pkg::ADDR_SOF_MODE, 8'h00);
    wr(rfd_pkg::ADDR_EOF_PATTERN, 8'he8);
    frame(8'h00);
    byte_q.push_back(8'h00);
    byte_q.push_back(8'hff);
    send_byte(8'h00, 1'b0, 1'b1, 8'h00);
    send_byte(8'hff, 1'b0, 1'b1, 8'h00);
    drain();
    check("eof disabled", 8'h01, {6'h0, frame_done, rx_active});
    // End symbol collision, zero, one: the highest active field comes first on the air.
    wr(rfd_pkg::ADDR_EOF_PATTERN, 8'h36);
    frame(8'h00);
    b = 8'($urandom);
    byte_q.push_back(b);
    send_byte(b, 1'b0, 1'b1, 8'h00);
    i_rfd_card.push(1'b0, 1'b1);
    i_rfd_card.push(1'b0, 1'b0);
    i_rfd_card.push(1'b1, 1'b0);
    drain();
    check("eof symbol", 8'h02, {6'h0, frame_done, rx_active});
    check("leftover bytes", 8'h00, 8'(byte_q.size()));
    summarize();
  end

  // Watchdog: the tests take far less than this span.
  initial begin
    #200000;
    fails++;
    summarize();
  end
endmodule
`default_nettype wire
